// >>> hw/ddr_ctl_end.sv
`include "ddr_pins_defs.svh"

module ddr_ctl_end #(
    parameter int DQ_W = 16,
    parameter int A_W = 4,
    parameter int FIFO_D = 16,
    localparam int LN = ddr_pins_pkg::lanes(DQ_W),
    localparam int RW = 3 + A_W + 2 * LN + 2 * DQ_W
) (
    // Link
    ddr_link_if.ctl link,
    // System
    input wire logic clk,
    input wire logic rst,
    // Requests
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [1:0] req_bank,
    input wire logic [A_W-1:0] req_addr,
    input wire logic [2*DQ_W-1:0] req_data,
    input wire logic [2*LN-1:0] req_mask,
    // Read answers
    output logic rd_valid,
    output logic [2*DQ_W-1:0] rd_data
);
    ddr_pins_pkg::ctl_state_t state_q, state_d;
    logic [1:0] ph_q, ph_d;
    logic ck_q, ck_d;
    logic [4:0] t_q, t_d, nt;
    logic [RW-1:0] cur_q, cur_d, f_data;
    logic f_valid, pop;
    logic cs_n_q, cs_n_d;
    logic [2:0] cmd_q, cmd_d;
    logic [1:0] bank_q, bank_d;
    logic [A_W-1:0] addr_q, addr_d;
    logic [LN-1:0] mask_q, mask_d, stb_q, stb_d;
    logic [DQ_W-1:0] data_q, data_d, lo_q, lo_d;
    logic doe_q, doe_d, soe_q, soe_d;
    logic [DQ_W-1:0] s1_q, s2_q;
    logic ss1_q, ss2_q, ss3_q;
    logic beats_q, beats_d;
    logic rdv_q, rdv_d;
    logic [2*DQ_W-1:0] rdd_q, rdd_d;
    logic cur_wr;

    ddr_req_fifo #(.W(RW), .D(FIFO_D)) req_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_bank, req_addr, req_mask, req_data}),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );

    assign link.ck = ck_q;
    assign link.chip_select_n = cs_n_q;
    assign {link.row_strobe_n, link.column_strobe_n, link.write_enable_n} = cmd_q;
    assign link.bank_select = bank_q;
    assign link.addr = addr_q;
    assign link.write_mask = mask_q;
    assign link.ctl_data_o = data_q;
    assign link.ctl_data_oe = doe_q;
    assign link.ctl_strobe_o = stb_q;
    assign link.ctl_strobe_oe = soe_q;
    assign rd_valid = rdv_q;
    assign rd_data = rdd_q;
    assign cur_wr = cur_q[RW-1];

    always_comb begin
        ph_d = ph_q + 2'h1;
        ck_d = (ph_d == 2'h0) || (ph_d == 2'h1);
        nt = t_q + 5'h01;
        state_d = state_q;
        t_d = t_q;
        cur_d = cur_q;
        cs_n_d = cs_n_q;
        cmd_d = cmd_q;
        bank_d = bank_q;
        addr_d = addr_q;
        mask_d = mask_q;
        stb_d = stb_q;
        data_d = data_q;
        doe_d = doe_q;
        soe_d = soe_q;
        lo_d = lo_q;
        beats_d = beats_q;
        rdv_d = 1'b0;
        rdd_d = rdd_q;
        pop = 1'b0;
        case (state_q)
            ddr_pins_pkg::CTL_IDLE: begin
                // Pins change at the falling link edge, half a period before the device samples
                if (ph_q == `PH_ISSUE && f_valid) begin
                    pop = 1'b1;
                    cur_d = f_data;
                    t_d = '0;
                    beats_d = 1'b0;
                    cs_n_d = 1'b0;
                    cmd_d = f_data[RW-1] ? `CMD_WRITE : `CMD_READ;
                    bank_d = f_data[RW-2 -: 2];
                    addr_d = f_data[RW-4 -: A_W];
                    state_d = ddr_pins_pkg::CTL_BUSY;
                end
            end
            ddr_pins_pkg::CTL_BUSY: begin
                t_d = nt;
                if (nt == `T_CMD_END) begin
                    cs_n_d = 1'b1;
                    cmd_d = `CMD_NOP;
                end
                if (cur_wr) begin
                    if (nt == `T_WBEAT0) begin
                        data_d = cur_q[DQ_W-1:0];
                        mask_d = cur_q[2*DQ_W +: LN];
                        doe_d = 1'b1;
                        soe_d = 1'b1;
                        stb_d = '0;
                    end
                    if (nt == `T_WSTB_RISE) begin
                        stb_d = '1;
                    end
                    if (nt == `T_WBEAT1) begin
                        data_d = cur_q[DQ_W +: DQ_W];
                        mask_d = cur_q[2*DQ_W+LN +: LN];
                    end
                    if (nt == `T_WSTB_FALL) begin
                        stb_d = '0;
                    end
                    if (nt == `T_WDONE) begin
                        doe_d = 1'b0;
                        soe_d = 1'b0;
                        mask_d = '0;
                        state_d = ddr_pins_pkg::CTL_IDLE;
                    end
                end else begin
                    // Each edge of the returned strobe marks a new beat
                    if (ss2_q != ss3_q) begin
                        if (!beats_q) begin
                            lo_d = s2_q;
                        end else begin
                            rdd_d = {s2_q, lo_q};
                            rdv_d = 1'b1;
                        end
                        beats_d = 1'b1;
                    end
                    if (nt == `T_RDONE) begin
                        state_d = ddr_pins_pkg::CTL_IDLE;
                    end
                end
            end
            default: begin
                state_d = ddr_pins_pkg::CTL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        s1_q <= link.data_i;
        s2_q <= s1_q;
        ss1_q <= link.data_strobe_i[0];
        ss2_q <= ss1_q;
        ss3_q <= ss2_q;
        if (rst) begin
            state_q <= ddr_pins_pkg::CTL_IDLE;
            ph_q <= '0;
            ck_q <= 1'b0;
            t_q <= '0;
            cur_q <= '0;
            cs_n_q <= 1'b1;
            cmd_q <= `CMD_NOP;
            bank_q <= '0;
            addr_q <= '0;
            mask_q <= '0;
            stb_q <= '0;
            data_q <= '0;
            doe_q <= 1'b0;
            soe_q <= 1'b0;
            lo_q <= '0;
            beats_q <= 1'b0;
            rdv_q <= 1'b0;
            rdd_q <= '0;
        end else begin
            state_q <= state_d;
            ph_q <= ph_d;
            ck_q <= ck_d;
            t_q <= t_d;
            cur_q <= cur_d;
            cs_n_q <= cs_n_d;
            cmd_q <= cmd_d;
            bank_q <= bank_d;
            addr_q <= addr_d;
            mask_q <= mask_d;
            stb_q <= stb_d;
            data_q <= data_d;
            doe_q <= doe_d;
            soe_q <= soe_d;
            lo_q <= lo_d;
            beats_q <= beats_d;
            rdv_q <= rdv_d;
            rdd_q <= rdd_d;
        end
    end
endmodule : ddr_ctl_end

// >>> hw/ddr_dev_end.sv
`include "ddr_pins_defs.svh"

module ddr_dev_end #(
    parameter int DQ_W = 16,
    parameter int A_W = 4,
    localparam int LN = ddr_pins_pkg::lanes(DQ_W),
    localparam int IW = A_W + 3
) (
    // Link
    ddr_link_if.dev link,
    // Device user side, on the link clock
    input wire logic rst,
    input wire logic [IW-1:0] peek_addr,
    output logic [DQ_W-1:0] peek_data
);
    localparam int LW = DQ_W / LN;
    localparam int DEPTH = 2 ** IW;

    ddr_pins_pkg::dev_state_t state_q, state_d;
    logic [A_W+1:0] idx_q, idx_d;
    logic [DQ_W-1:0] data_q, data_d, peek_q, peek_d;
    logic doe_q, doe_d, soe_q, soe_d;
    logic [LN-1:0] stb_q, stb_d;
    logic store;
    wire [DQ_W-1:0] rd_word0, rd_word1, peek_word;

    genvar g;
    for (g = 0; g < LN; g++) begin : lane
        logic [LW-1:0] rise_q, fall_q;
        logic rmask_q, fmask_q;
        logic [LW-1:0] mem_q [DEPTH];

        // Source-synchronous capture: one beat and one mask bit per strobe edge
        always_ff @(posedge link.data_strobe_i[g]) begin
            rise_q <= link.data_i[g*LW +: LW];
            rmask_q <= link.write_mask[g];
        end
        always_ff @(negedge link.data_strobe_i[g]) begin
            fall_q <= link.data_i[g*LW +: LW];
            fmask_q <= link.write_mask[g];
        end

        // Captures are stable at least a quarter link period before this edge
        always_ff @(posedge link.ck) begin
            if (store && !rmask_q) begin
                mem_q[{idx_q, 1'b0}] <= rise_q;
            end
            if (store && !fmask_q) begin
                mem_q[{idx_q, 1'b1}] <= fall_q;
            end
        end

        assign rd_word0[g*LW +: LW] = mem_q[{idx_q, 1'b0}];
        assign rd_word1[g*LW +: LW] = mem_q[{idx_q, 1'b1}];
        assign peek_word[g*LW +: LW] = mem_q[peek_addr];
    end

    assign link.dev_data_o = data_q;
    assign link.dev_data_oe = doe_q;
    assign link.dev_strobe_o = stb_q;
    assign link.dev_strobe_oe = soe_q;
    assign peek_data = peek_q;

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        data_d = data_q;
        doe_d = doe_q;
        stb_d = stb_q;
        soe_d = soe_q;
        peek_d = peek_word;
        store = 1'b0;
        case (state_q)
            ddr_pins_pkg::DEV_IDLE: begin
                if (!link.chip_select_n) begin
                    if ({link.row_strobe_n, link.column_strobe_n, link.write_enable_n} == `CMD_READ) begin
                        idx_d = {link.bank_select, link.addr};
                        state_d = ddr_pins_pkg::DEV_RD_B0;
                    end else if ({link.row_strobe_n, link.column_strobe_n, link.write_enable_n} == `CMD_WRITE) begin
                        idx_d = {link.bank_select, link.addr};
                        state_d = ddr_pins_pkg::DEV_WR_GAP;
                    end
                end
            end
            ddr_pins_pkg::DEV_WR_GAP: begin
                state_d = ddr_pins_pkg::DEV_WR_TAKE;
            end
            ddr_pins_pkg::DEV_WR_TAKE: begin
                store = 1'b1;
                state_d = ddr_pins_pkg::DEV_IDLE;
            end
            ddr_pins_pkg::DEV_RD_B0: begin
                // Strobe rises in the same edge that launches the first beat
                data_d = rd_word0;
                doe_d = 1'b1;
                stb_d = '1;
                soe_d = 1'b1;
                state_d = ddr_pins_pkg::DEV_RD_B1;
            end
            ddr_pins_pkg::DEV_RD_B1: begin
                data_d = rd_word1;
                stb_d = '0;
                state_d = ddr_pins_pkg::DEV_RD_END;
            end
            ddr_pins_pkg::DEV_RD_END: begin
                doe_d = 1'b0;
                soe_d = 1'b0;
                state_d = ddr_pins_pkg::DEV_IDLE;
            end
            default: begin
                state_d = ddr_pins_pkg::DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge link.ck) begin
        if (rst) begin
            state_q <= ddr_pins_pkg::DEV_IDLE;
            idx_q <= '0;
            data_q <= '0;
            doe_q <= 1'b0;
            stb_q <= '0;
            soe_q <= 1'b0;
            peek_q <= '0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            data_q <= data_d;
            doe_q <= doe_d;
            stb_q <= stb_d;
            soe_q <= soe_d;
            peek_q <= peek_d;
        end
    end
endmodule : ddr_dev_end

// >>> hw/ddr_link_if.sv
interface ddr_link_if #(
    parameter int DQ_W = 16,
    parameter int A_W = 4
);
    localparam int LN = ddr_pins_pkg::lanes(DQ_W);

    logic ck;
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_enable_n;
    logic [1:0] bank_select;
    logic [A_W-1:0] addr;
    logic [LN-1:0] write_mask;
    logic [DQ_W-1:0] dev_data_o;
    logic dev_data_oe;
    logic [DQ_W-1:0] ctl_data_o;
    logic ctl_data_oe;
    logic [DQ_W-1:0] data_i;
    logic [LN-1:0] dev_strobe_o;
    logic dev_strobe_oe;
    logic [LN-1:0] ctl_strobe_o;
    logic ctl_strobe_oe;
    logic [LN-1:0] data_strobe_i;

    // Wire level from whichever end drives; an undriven bus reads low
    assign data_i = dev_data_oe ? dev_data_o : (ctl_data_oe ? ctl_data_o : '0);
    assign data_strobe_i = dev_strobe_oe ? dev_strobe_o : (ctl_strobe_oe ? ctl_strobe_o : '0);

    modport dev (
        input ck, chip_select_n, row_strobe_n, column_strobe_n, write_enable_n, bank_select, addr, write_mask,
        input data_i, data_strobe_i,
        output dev_data_o, dev_data_oe, dev_strobe_o, dev_strobe_oe
    );
    modport ctl (
        output ck, chip_select_n, row_strobe_n, column_strobe_n, write_enable_n, bank_select, addr, write_mask,
        input data_i, data_strobe_i,
        output ctl_data_o, ctl_data_oe, ctl_strobe_o, ctl_strobe_oe
    );
endinterface : ddr_link_if

// >>> hw/ddr_pins_defs.svh
`ifndef DDR_PINS_DEFS_SVH
`define DDR_PINS_DEFS_SVH
// Contract
// - Commands decoded only while chip select low
// - Select plus three strobes jointly encode command
// - Controller selects one device by its select
// - Masked write beats are never stored
// - Mask sampled on both strobe edges
// - Lower and upper masks cover separate bytes
// - Strobe travels with data, driven by sender
// - Read strobe edge-aligned, write strobe centred
// - Lower and upper strobes accompany own bytes; controller read capture times both bytes from the lower strobe only
// - Data bus width is 16, 8 or 4
// - Command inputs sampled at rising link clock
// - Bank select picks the targeted bank

// Command codes as {row_strobe_n, column_strobe_n, write_enable_n}
`define CMD_NOP 3'h7
`define CMD_READ 3'h5
`define CMD_WRITE 3'h4

// Link clock phases: four system clocks per link clock, high in phases 0 and 1
`define PH_ISSUE 2'h1

// Controller step counts, in system clocks after the command is driven
`define T_CMD_END 5'h04
`define T_WBEAT0 5'h06
`define T_WSTB_RISE 5'h07
`define T_WBEAT1 5'h08
`define T_WSTB_FALL 5'h09
`define T_WDONE 5'h0A
`define T_RDONE 5'h10
`endif

// >>> hw/ddr_pins_pkg.sv
package ddr_pins_pkg;
    typedef enum logic [2:0] {DEV_IDLE, DEV_WR_GAP, DEV_WR_TAKE, DEV_RD_B0, DEV_RD_B1, DEV_RD_END} dev_state_t;
    typedef enum logic [1:0] {CTL_IDLE, CTL_BUSY} ctl_state_t;

    // Byte lanes: the 16-bit part has separate lower and upper lanes
    function automatic int lanes(input int w);
        return (w == 16) ? 2 : 1;
    endfunction : lanes
endpackage : ddr_pins_pkg

// >>> hw/ddr_req_fifo.sv
module ddr_req_fifo #(
    parameter int W = 8,
    parameter int D = 16,
    localparam int AW = $clog2(D)
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    logic ready_q, ready_d;

    assign in_ready = ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        ready_d = (cnt_d != (AW+1)'(D));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : ddr_req_fifo

// >>> tb/ddr_link_chk.sv
module ddr_link_chk #(
    parameter int DQ_W = 16,
    parameter int A_W = 4,
    localparam int LN = ddr_pins_pkg::lanes(DQ_W)
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Command lines
    input wire logic ck,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic [1:0] bank_select,
    input wire logic [A_W-1:0] addr,
    input wire logic [LN-1:0] write_mask,
    // Data lines
    input wire logic [DQ_W-1:0] dev_data_o,
    input wire logic dev_data_oe,
    input wire logic [DQ_W-1:0] ctl_data_o,
    input wire logic ctl_data_oe,
    input wire logic [LN-1:0] dev_strobe_o,
    input wire logic dev_strobe_oe,
    input wire logic [LN-1:0] ctl_strobe_o,
    input wire logic ctl_strobe_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cmd;
    assign cmd = {row_strobe_n, column_strobe_n, write_enable_n};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_idle_is_nop: assert property (chip_select_n |-> cmd == 3'h7)
        else $error("command lines busy while deselected");
    a_cmd_held: assert property ($fell(chip_select_n) |=>
        (!chip_select_n && $stable({cmd, bank_select, addr}))[*3] ##1 chip_select_n)
        else $error("command not held for one link clock");
    a_cmd_at_ck: assert property ($fell(chip_select_n) |-> ##2 $rose(ck))
        else $error("command not centred on link clock rise");
    a_wdata_start: assert property ($fell(chip_select_n) && cmd == 3'h4 |-> ##6 $rose(ctl_data_oe))
        else $error("write data late or early");
    a_wdata_len: assert property ($rose(ctl_data_oe) |-> ctl_data_oe[*4] ##1 !ctl_data_oe)
        else $error("write data window wrong length");
    a_wstb_centre: assert property (ctl_strobe_oe && $past(ctl_strobe_oe) && $changed(ctl_strobe_o)
        |-> $stable(ctl_data_o) && $stable(write_mask))
        else $error("write strobe edge not inside beat");
    a_strobe_follows: assert property ((ctl_strobe_oe == ctl_data_oe) && (dev_strobe_oe == dev_data_oe))
        else $error("strobe drive differs from data drive");
    a_one_driver: assert property (!(dev_data_oe && ctl_data_oe))
        else $error("both ends drive data");
    a_read_launch: assert property ($fell(chip_select_n) && cmd == 3'h5
        |-> ##[4:8] ($rose(dev_data_oe) && dev_strobe_o == '1))
        else $error("read data not launched");
    a_read_edge: assert property (dev_data_oe && $past(dev_data_oe) && $changed(dev_data_o)
        |-> $changed(dev_strobe_o))
        else $error("read strobe not edge aligned");
    a_mask_idle: assert property (!ctl_data_oe |-> write_mask == '0)
        else $error("mask active outside write data");
endmodule : ddr_link_chk

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dev_rst = 1'b1;
    logic rst2 = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_bank = 2'h0;
    logic [3:0] req_addr = 4'h0;
    logic [31:0] req_data = 32'h0;
    logic [3:0] req_mask = 4'h0;
    logic [6:0] peek_addr = 7'h00;
    logic [6:0] peek2_addr = 7'h00;
    logic req_ready;
    logic rd_valid;
    logic [31:0] rd_data;
    logic [15:0] peek_data;
    logic [15:0] peek2_data;
    logic [31:0] shadow [4][16];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    ddr_link_if link1 ();
    ddr_link_if link2 ();
    ddr_ctl_end u_ddr_ctl_end (.link(link1.ctl), .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_bank(req_bank), .req_addr(req_addr), .req_data(req_data), .req_mask(req_mask),
        .rd_valid(rd_valid), .rd_data(rd_data));
    ddr_dev_end u_ddr_dev_end (.link(link1.dev), .rst(dev_rst), .peek_addr(peek_addr), .peek_data(peek_data));
    ddr_dev_end u_ddr_dev_end_b (.link(link2.dev), .rst(rst2), .peek_addr(peek2_addr), .peek_data(peek2_data));
    ddr_link_chk u_chk (.clk(clk), .rst(dev_rst), .ck(link1.ck), .chip_select_n(link1.chip_select_n),
        .row_strobe_n(link1.row_strobe_n), .column_strobe_n(link1.column_strobe_n),
        .write_enable_n(link1.write_enable_n), .bank_select(link1.bank_select), .addr(link1.addr),
        .write_mask(link1.write_mask), .dev_data_o(link1.dev_data_o), .dev_data_oe(link1.dev_data_oe),
        .ctl_data_o(link1.ctl_data_o), .ctl_data_oe(link1.ctl_data_oe), .dev_strobe_o(link1.dev_strobe_o),
        .dev_strobe_oe(link1.dev_strobe_oe), .ctl_strobe_o(link1.ctl_strobe_o), .ctl_strobe_oe(link1.ctl_strobe_oe));

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk

    // Expected memory tracks each unmasked byte lane
    task automatic push(input logic w, input logic [1:0] b, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] m);
        req_valid <= 1'b1;
        req_write <= w;
        req_bank <= b;
        req_addr <= a;
        req_data <= d;
        req_mask <= m;
        @(posedge clk);
        while (req_ready !== 1'b1) @(posedge clk);
        req_valid <= 1'b0;
        for (int i = 0; i < 4; i++) if (w && !m[i]) shadow[b][a][8*i +: 8] = d[8*i +: 8];
        @(posedge clk);
    endtask : push

    task automatic rd(input logic [1:0] b, input logic [3:0] a);
        int n;
        n = 0;
        push(1'b0, b, a, 32'h0, 4'h0);
        while (rd_valid !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk("read answer", 32'h1, {31'h0, rd_valid});
        chk("read data", shadow[b][a], rd_data);
    endtask : rd

    task automatic t_banks;
        for (int b = 0; b < 4; b++) push(1'b1, b[1:0], 4'h5, 32'h0F1E_2D3C + b, 4'h0);
        for (int b = 0; b < 4; b++) rd(b[1:0], 4'h5);
    endtask : t_banks

    task automatic t_masks;
        for (int m = 0; m < 16; m++) begin
            push(1'b1, 2'h1, 4'h9, ~(32'h0101_0101 * m), m[3:0]);
            rd(2'h1, 4'h9);
        end
        peek_addr <= 7'h33;
        repeat (12) @(posedge clk);
        chk("stored upper beat", {16'h0, shadow[1][9][31:16]}, {16'h0, peek_data});
    endtask : t_masks

    // Request buffer refuses requests while kept full; the link keeps draining it
    task automatic t_fill;
        int n;
        logic full;
        n = 0;
        full = 1'b0;
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_bank <= 2'h2;
        req_mask <= 4'h0;
        req_addr <= 4'h0;
        req_data <= 32'hB000_0000;
        repeat (40) begin
            @(posedge clk);
            if (req_ready === 1'b1) begin
                shadow[2][n % 16] = 32'hB000_0000 + n;
                n++;
                req_addr <= 4'(n);
                req_data <= 32'hB000_0000 + n;
            end else full = 1'b1;
        end
        req_valid <= 1'b0;
        @(posedge clk);
        chk("fifo refused", 32'h1, {31'h0, full});
        chk("fifo depth", 32'h1, {31'h0, n >= 16});
        for (int a = 0; a < 16; a++) rd(2'h2, a[3:0]);
    endtask : t_fill

    task automatic ck2(input int n);
        repeat (n) begin
            #32 link2.ck <= 1'b1;
            #32 link2.ck <= 1'b0;
        end
    endtask : ck2

    // Second device driven directly; strobe edges lag link clock edges by a quarter period
    task automatic drv2(input logic cs_n, input logic [15:0] b0, input logic [15:0] b1);
        {link2.chip_select_n, link2.row_strobe_n, link2.column_strobe_n, link2.write_enable_n} <= {cs_n, 3'h4};
        #16 link2.ck <= 1'b1;
        #32 link2.ck <= 1'b0;
        {link2.chip_select_n, link2.row_strobe_n, link2.column_strobe_n, link2.write_enable_n} <= 4'hF;
        {link2.ctl_data_o, link2.ctl_data_oe, link2.ctl_strobe_oe, link2.ctl_strobe_o} <= {b0, 4'hC};
        #32 link2.ck <= 1'b1;
        #16 link2.ctl_strobe_o <= 2'h3;
        #16 link2.ck <= 1'b0;
        link2.ctl_data_o <= b1;
        #16 link2.ctl_strobe_o <= 2'h0;
        #16 link2.ck <= 1'b1;
        #16 {link2.ctl_data_oe, link2.ctl_strobe_oe} <= 2'h0;
        #16 link2.ck <= 1'b0;
    endtask : drv2

    task automatic t_select;
        ck2(2);
        rst2 <= 1'b0;
        drv2(1'b0, 16'h1357, 16'h2468);
        drv2(1'b1, 16'hDEAD, 16'hBEEF);
        peek2_addr <= 7'h00;
        ck2(1);
        chk("selected beat0", 32'h1357, {16'h0, peek2_data});
        peek2_addr <= 7'h01;
        ck2(1);
        chk("deselected beat1", 32'h2468, {16'h0, peek2_data});
    endtask : t_select

    initial begin
        forever #10 clk = ~clk;
    end

    initial begin
        {link2.ck, link2.chip_select_n, link2.row_strobe_n, link2.column_strobe_n, link2.write_enable_n} = 5'h0F;
        {link2.bank_select, link2.addr, link2.write_mask} = '0;
        {link2.ctl_data_o, link2.ctl_data_oe, link2.ctl_strobe_o, link2.ctl_strobe_oe} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        dev_rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_banks;
        t_masks;
        t_fill;
        t_select;
        give_verdict;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict;
        end
    end
endmodule : testbench
